// ---- design/rmc_clock_config.sv ----
/*
  run-mode clock configuration register block with an AHB-Lite slave port.
  holds the run-mode config, a second config and a read-only status word, and drives the
  clock-tree controls (pll power-down, source select, effective divisor, oscillator selects).
  assumes one 100 MHz clock, word-sized single transfers, and a single bus master.
*/
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module rmc_clock_config #(
  parameter logic [5:0] MIN_DIV_LIMIT = 6'h03 // smallest divisor code allowed with the pll
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic pll_power_down,
  output logic sys_clk_from_pll,
  output logic div_active,
  output logic [5:0] sys_div_value,
  output logic [1:0] oscillator_source_select,
  output logic [3:0] crystal_freq_code,
  output logic [31:0] crystal_hz,
  output logic auto_gating,
  output logic main_osc_disable,
  output logic int_osc_disable
);
  import rmc_pkg::*;

  // refuse a limit of zero, which would put no floor under the divisor code
  if (MIN_DIV_LIMIT == 6'h00) begin : g_bad_limit
    $error("MIN_DIV_LIMIT must be above zero");
  end

  // address phase capture
  logic dp_valid; // a transfer is in its data phase
  logic dp_write; // that transfer is a write
  logic [11:0] dp_addr; // its low address bits

  // register storage
  logic [31:0] run_mode_clock_config; // run-mode clock config word
  logic [31:0] second_clock_config_register; // second config word
  logic [31:0] next_run_cfg; // value after this cycle's write
  logic [31:0] next_second_cfg;

  // address-phase decode
  wire ap_take = hsel & htrans[1] & hready; // a transfer is accepted this edge
  wire [11:0] ap_addr = haddr[11:0];
  // only the lowest page is decoded; an address above it misses every register
  wire ap_upper_zero = (haddr[31:12] == 20'h0_0000);
  wire ap_hit_run = (ap_addr == RMC_OFS_RUN_CFG) & (haddr[31:12] == 20'h0_0000);
  wire ap_hit_second = (ap_addr == RMC_OFS_SECOND_CFG) & (haddr[31:12] == 20'h0_0000);
  wire ap_hit_status = (ap_addr == RMC_OFS_STATUS) & (haddr[31:12] == 20'h0_0000);

  // data-phase write strobes
  wire wr_run = dp_valid & dp_write & (dp_addr == RMC_OFS_RUN_CFG);
  wire wr_second = dp_valid & dp_write & (dp_addr == RMC_OFS_SECOND_CFG);

  // pending register values, reserved bits kept at their fixed level
  assign next_run_cfg = wr_run ? ((hwdata & RMC_RUN_CFG_WMASK) | RMC_RUN_CFG_FIXED) :
                        run_mode_clock_config;
  assign next_second_cfg = wr_second ? (hwdata & RMC_SECOND_CFG_WMASK) : second_clock_config_register;

  // field views of the pending values
  wire use_second_config = next_second_cfg[RMC_BIT_USE_SECOND];
  wire [5:0] alternate_divisor_field = next_second_cfg[RMC_ALT_DIV_LSB +: 6];
  wire [3:0] system_divisor_field = next_run_cfg[RMC_SYSTEM_DIVISOR_FIELD_LSB +: 4];
  wire divider_enable = next_run_cfg[RMC_BIT_DIV_ENABLE];
  wire pll_skip = next_run_cfg[RMC_BIT_PLL_SKIP];
  wire [3:0] crystal_freq_code_code = next_run_cfg[RMC_CRYSTAL_FREQ_CODE_LSB +: 4];

  // divisor choice: second config overrides the run-mode field
  wire [5:0] raw_div = use_second_config ? alternate_divisor_field : {2'h0, system_divisor_field};
  wire pll_in_use = ~pll_skip;
  wire below_limit = raw_div < MIN_DIV_LIMIT;
  wire [5:0] eff_div = (pll_in_use & below_limit) ? MIN_DIV_LIMIT : raw_div;
  wire div_used = divider_enable | pll_in_use;
  // a crystal code that only suits oscillator-only operation while the pll is chosen
  wire crystal_freq_code_bad = pll_in_use & (crystal_freq_code_code <= RMC_CRYSTAL_FREQ_CODE_LAST_NO_PLL);

  // settled views of the stored words; every clock-tree output is built from these, so the
  // source select, the divisor and the divider enable all change on the same edge
  wire cur_use_second = second_clock_config_register[RMC_BIT_USE_SECOND];
  wire [5:0] cur_raw_div = cur_use_second ? second_clock_config_register[RMC_ALT_DIV_LSB +: 6] :
                           {2'h0, run_mode_clock_config[RMC_SYSTEM_DIVISOR_FIELD_LSB +: 4]};
  wire cur_pll_in_use = ~run_mode_clock_config[RMC_BIT_PLL_SKIP];
  wire [5:0] cur_eff_div = (cur_pll_in_use & (cur_raw_div < MIN_DIV_LIMIT)) ? MIN_DIV_LIMIT : cur_raw_div;
  wire cur_div_used = run_mode_clock_config[RMC_BIT_DIV_ENABLE] | cur_pll_in_use;
  wire [3:0] cur_crystal_freq_code_code = run_mode_clock_config[RMC_CRYSTAL_FREQ_CODE_LSB +: 4];

  // status word built from the pending configuration
  wire [31:0] status_word = {18'h0_0000, eff_div, 5'h00, crystal_freq_code_bad, div_used, pll_in_use};

  // read mux; unmapped addresses read zero
  wire [31:0] rd_mux = ap_hit_run ? next_run_cfg :
                       ap_hit_second ? next_second_cfg :
                       ap_hit_status ? status_word : 32'h0000_0000;

  // crystal frequency lookup
  logic [31:0] crystal_freq_code_hz;
  rmc_crystal_freq_code_table rmc_crystal_freq_code_table_i (
    .code(cur_crystal_freq_code_code),
    .freq_hz(crystal_freq_code_hz)
  );

  // address phase register; a transfer is always accepted with no wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
    end else begin
      dp_valid <= ap_take & ap_upper_zero; // a miss above the page never writes
      dp_write <= hwrite;
      dp_addr <= ap_addr;
    end
  end

  // configuration registers with documented reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_mode_clock_config <= RMC_RUN_CFG_RESET;
      second_clock_config_register <= RMC_SECOND_CFG_RESET;
    end else begin
      run_mode_clock_config <= next_run_cfg;
      second_clock_config_register <= next_second_cfg;
    end
  end

  // bus answer: read data is loaded at the address phase from pending values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (ap_take & ~hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // clock-tree controls, each straight from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_power_down <= RMC_RUN_CFG_RESET[RMC_BIT_PLL_PLL_POWER_DOWN];
      sys_clk_from_pll <= 1'b0;
      div_active <= 1'b0;
      sys_div_value <= 6'h0f;
      oscillator_source_select <= RMC_OSC_INTERNAL;
      crystal_freq_code <= RMC_CRYSTAL_FREQ_CODE_RESET;
      crystal_hz <= 32'd6_000_000;
      auto_gating <= 1'b0;
      main_osc_disable <= 1'b1;
      int_osc_disable <= 1'b0;
    end else begin
      pll_power_down <= run_mode_clock_config[RMC_BIT_PLL_PLL_POWER_DOWN];
      sys_clk_from_pll <= ~run_mode_clock_config[RMC_BIT_PLL_SKIP];
      div_active <= cur_div_used;
      sys_div_value <= cur_eff_div;
      oscillator_source_select <= run_mode_clock_config[RMC_OSC_LSB +: 2];
      crystal_freq_code <= run_mode_clock_config[RMC_CRYSTAL_FREQ_CODE_LSB +: 4];
      crystal_hz <= crystal_freq_code_hz;
      auto_gating <= run_mode_clock_config[RMC_BIT_AUTO_GATING];
      main_osc_disable <= run_mode_clock_config[RMC_BIT_MAIN_OSC_DIS];
      int_osc_disable <= run_mode_clock_config[RMC_BIT_INT_OSC_DIS];
    end
  end

  // helper: has any write reached the run-mode register since reset
  logic run_written;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_written <= 1'b0;
    end else begin
      run_written <= run_written | wr_run;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // a write of bit 13 reaches the pll power-down pin two edges later
  sequence s_run_write;
    wr_run;
  endsequence
  property p_pll_power_down_follows;
    s_run_write |-> ##2 (pll_power_down == $past(hwdata[RMC_BIT_PLL_PLL_POWER_DOWN], 2));
  endproperty
  AST_PLL_POWER_DOWN_FOLLOWS: assert property (p_pll_power_down_follows)
    else $error("pll power-down does not follow written bit");

  AST_PLL_POWER_DOWN_RESET: assert property (!run_written |-> pll_power_down)
    else $error("pll not powered down before first write");

  AST_SKIP_SELECT: assert property (##1 (sys_clk_from_pll == !$past(run_mode_clock_config[RMC_BIT_PLL_SKIP])))
    else $error("system clock source does not follow skip bit");

  AST_MIN_DIV: assert property (sys_clk_from_pll |-> sys_div_value >= MIN_DIV_LIMIT)
    else $error("divisor below limit while pll in use");

  AST_FORCE_DIV: assert property (sys_clk_from_pll |-> div_active)
    else $error("divider not forced with pll selected");

  AST_ALT_DIV: assert property ((second_clock_config_register[RMC_BIT_USE_SECOND] && !wr_second && !wr_run
      && run_mode_clock_config[RMC_BIT_PLL_SKIP]) |=> sys_div_value == $past(alternate_divisor_field))
    else $error("alternate divisor not used");

  AST_CRYSTAL_FREQ_CODE_CODE: assert property (##1 (crystal_freq_code == $past(run_mode_clock_config[RMC_CRYSTAL_FREQ_CODE_LSB +: 4])))
    else $error("crystal code output does not follow register");

  AST_CRYSTAL_FREQ_CODE_HZ: assert property ((crystal_freq_code == 4'h4) |-> crystal_hz == 32'd3_579_545)
    else $error("crystal frequency mismatch");

  AST_RESERVED: assert property (run_mode_clock_config[21:14] == 8'h00 && run_mode_clock_config[12]
      && !run_mode_clock_config[10] && run_mode_clock_config[31:28] == 4'h0)
    else $error("reserved bits changed");

  AST_OSC_SRC: assert property (##1 (oscillator_source_select == $past(run_mode_clock_config[RMC_OSC_LSB +: 2])))
    else $error("oscillator source output does not follow register");

  // bus answer: zero wait states
  AST_READY_HIGH: assert property (hreadyout)
    else $error("slave inserted a wait state");

  // bus answer: always an okay response
  AST_RESP_OKAY: assert property (!hresp)
    else $error("slave answered with an error response");

  // read data stands only during a read data phase
  AST_RDATA_IDLE: assert property ((!dp_valid || dp_write) |-> hrdata == 32'h0000_0000)
    else $error("read data driven outside a read data phase");

  // a run-mode write keeps only the writable bits and the fixed one
  AST_RUN_WRITE: assert property (wr_run |=>
      run_mode_clock_config == (($past(hwdata) & RMC_RUN_CFG_WMASK) | RMC_RUN_CFG_FIXED))
    else $error("run-mode word does not hold the written value");

  // the run-mode word only moves on a write
  AST_RUN_HOLD: assert property (!wr_run |=> $stable(run_mode_clock_config))
    else $error("run-mode word changed without a write");

  // the second word takes only its override bit and alternate divisor
  AST_SECOND_WRITE: assert property (wr_second |=>
      second_clock_config_register == ($past(hwdata) & RMC_SECOND_CFG_WMASK))
    else $error("second word does not hold the written value");

  // the second word only moves on a write
  AST_SECOND_HOLD: assert property (!wr_second |=> $stable(second_clock_config_register))
    else $error("second word changed without a write");

  // bits of the second word outside its fields stay clear
  AST_SECOND_UNUSED: assert property (second_clock_config_register[30:29] == 2'h0
      && second_clock_config_register[22:0] == 23'h00_0000)
    else $error("unused bits of the second word are set");

  // steady oscillator clocking from the run-mode divisor field
  sequence s_run_div_bypass;
    !second_clock_config_register[RMC_BIT_USE_SECOND] && run_mode_clock_config[RMC_BIT_PLL_SKIP]
      && !wr_run && !wr_second;
  endsequence
  AST_RUN_DIV: assert property (s_run_div_bypass |=>
      sys_div_value == {2'h0, $past(run_mode_clock_config[RMC_SYSTEM_DIVISOR_FIELD_LSB +: 4])})
    else $error("run-mode divisor not passed through");

  // steady pll clocking: the divisor never drops below the floor
  sequence s_pll_quiet;
    !run_mode_clock_config[RMC_BIT_PLL_SKIP] && !wr_run && !wr_second;
  endsequence
  AST_PLL_DIV: assert property (s_pll_quiet |=> sys_div_value ==
      (($past(cur_raw_div) < MIN_DIV_LIMIT) ? MIN_DIV_LIMIT : $past(cur_raw_div)))
    else $error("divisor under the pll is not the clamped request");

  // without the pll a divisor under the floor is honoured
  sequence s_bypass_small;
    run_mode_clock_config[RMC_BIT_PLL_SKIP] && (cur_raw_div < MIN_DIV_LIMIT) && !wr_run && !wr_second;
  endsequence
  AST_SMALL_DIV: assert property (s_bypass_small |=> sys_div_value == $past(cur_raw_div))
    else $error("small divisor clamped without the pll");

  // each plain control output is its stored bit one edge later
  AST_PLL_POWER_DOWN_LEVEL: assert property (##1 (pll_power_down == $past(run_mode_clock_config[RMC_BIT_PLL_PLL_POWER_DOWN])))
    else $error("pll power-down does not match its bit");

  // divider in use when enabled or when the pll is chosen
  AST_DIV_ENABLE: assert property (##1 (div_active == ($past(run_mode_clock_config[RMC_BIT_DIV_ENABLE])
      || !$past(run_mode_clock_config[RMC_BIT_PLL_SKIP]))))
    else $error("divider use does not follow enable and source");

  // sleep gating choice passes straight through
  AST_GATING: assert property (##1 (auto_gating == $past(run_mode_clock_config[RMC_BIT_AUTO_GATING])))
    else $error("auto gating does not follow its bit");

  // oscillator disables pass straight through
  AST_OSC_DISABLE: assert property (##1 (main_osc_disable == $past(run_mode_clock_config[RMC_BIT_MAIN_OSC_DIS])
      && int_osc_disable == $past(run_mode_clock_config[RMC_BIT_INT_OSC_DIS])))
    else $error("oscillator disables do not follow their bits");

  // two more points of the crystal table: the reset code and a middle code
  AST_CRYSTAL_FREQ_CODE_RESET_HZ: assert property ((crystal_freq_code == RMC_CRYSTAL_FREQ_CODE_RESET) |-> crystal_hz == 32'h005b_8d80)
    else $error("reset crystal code frequency mismatch");

  AST_CRYSTAL_FREQ_CODE_MID_HZ: assert property ((crystal_freq_code == 4'h6) |-> crystal_hz == 32'h003d_0900)
    else $error("middle crystal code frequency mismatch");

endmodule : rmc_clock_config

// ---- design/rmc_crystal_freq_code_table.sv ----
/*
  crystal code to frequency lookup (in hertz) for the main oscillator.
  assumes the code is stable in the bus clock domain; purely combinational.
*/
`timescale 1ns/1ps
module rmc_crystal_freq_code_table (
  input wire logic [3:0] code,
  output logic [31:0] freq_hz
);
  import rmc_pkg::*;

  // constant lookup of the crystal frequency
  always_comb begin
    unique case (code)
      4'h0: freq_hz = 32'd1_000_000; // not for pll use
      4'h1: freq_hz = 32'd1_843_200; // not for pll use
      4'h2: freq_hz = 32'd2_000_000; // not for pll use
      4'h3: freq_hz = 32'd2_457_600; // not for pll use
      4'h4: freq_hz = 32'd3_579_545;
      4'h5: freq_hz = 32'd3_686_400;
      4'h6: freq_hz = 32'd4_000_000;
      4'h7: freq_hz = 32'd4_096_000;
      4'h8: freq_hz = 32'd4_915_200;
      4'h9: freq_hz = 32'd5_000_000;
      4'ha: freq_hz = 32'd5_120_000;
      4'hb: freq_hz = 32'd6_000_000; // reset code
      4'hc: freq_hz = 32'd6_144_000;
      4'hd: freq_hz = 32'd7_372_800;
      4'he: freq_hz = 32'd8_000_000;
      4'hf: freq_hz = 32'd8_192_000;
    endcase
  end
endmodule : rmc_crystal_freq_code_table

// ---- design/rmc_pkg.sv ----
/*
  constants for the run-mode clock configuration block: register offsets, field positions,
  reset values, write masks and the crystal code bounds.
  assumes a single 100 MHz bus clock and a 32-bit AHB-Lite register bus.
*/
// What this block does
// - second config bit selects alternate divisor field
// - bit 13 drives pll power-down directly
// - pll power-down resets to one
// - skip bit set clocks from oscillator source
// - skip bit clear clocks from divided pll
// - crystal code in bits 9:6, reset 0xb
// - crystal codes 0 to 0xf map frequencies
// - pll nominal 400 MHz, crystal dependent
// - pll in use enforces minimum divisor limit
// - pll selected forces divider use
// - oscillator source codes 0 to 3
package rmc_pkg;
  // byte offsets of the registers
  localparam logic [11:0] RMC_OFS_RUN_CFG = 12'h060; // run-mode clock config
  localparam logic [11:0] RMC_OFS_SECOND_CFG = 12'h070; // second clock config
  localparam logic [11:0] RMC_OFS_STATUS = 12'h074; // effective clock status
  // run-mode clock config fields
  localparam int RMC_BIT_AUTO_GATING = 27;
  localparam int RMC_SYSTEM_DIVISOR_FIELD_LSB = 23;
  localparam int RMC_BIT_DIV_ENABLE = 22;
  localparam int RMC_BIT_PLL_PLL_POWER_DOWN = 13;
  localparam int RMC_BIT_PLL_SKIP = 11;
  localparam int RMC_CRYSTAL_FREQ_CODE_LSB = 6;
  localparam int RMC_OSC_LSB = 4;
  localparam int RMC_BIT_INT_OSC_DIS = 1;
  localparam int RMC_BIT_MAIN_OSC_DIS = 0;
  localparam logic [31:0] RMC_RUN_CFG_RESET = 32'h0780_3ad1;
  localparam logic [31:0] RMC_RUN_CFG_WMASK = 32'h0fc0_2bf3; // writable bits
  localparam logic [31:0] RMC_RUN_CFG_FIXED = 32'h0000_1000; // reserved bit reading one
  // second clock config fields
  localparam int RMC_BIT_USE_SECOND = 31;
  localparam int RMC_ALT_DIV_LSB = 23;
  localparam logic [31:0] RMC_SECOND_CFG_RESET = 32'h0f80_0000;
  localparam logic [31:0] RMC_SECOND_CFG_WMASK = 32'h9f80_0000;
  // status fields
  localparam int RMC_ST_PLL_IN_USE = 0;
  localparam int RMC_ST_DIV_USED = 1;
  localparam int RMC_ST_CRYSTAL_FREQ_CODE_BAD = 2;
  localparam int RMC_ST_DIV_LSB = 8;
  // crystal code bounds
  localparam logic [3:0] RMC_CRYSTAL_FREQ_CODE_RESET = 4'hb;
  localparam logic [3:0] RMC_CRYSTAL_FREQ_CODE_LAST_NO_PLL = 4'h3; // codes up to here are not for pll use
  // oscillator source codes
  localparam logic [1:0] RMC_OSC_MAIN = 2'h0;
  localparam logic [1:0] RMC_OSC_INTERNAL = 2'h1;
  localparam logic [1:0] RMC_OSC_INTERNAL_DIV4 = 2'h2;
  localparam logic [1:0] RMC_OSC_30K = 2'h3;
  // nominal pll output in hertz
  localparam logic [31:0] RMC_PLL_NOMINAL_HZ = 32'd400_000_000;
endpackage : rmc_pkg

// ---- verif/tb_rmc_clock_config.sv ----
/*
  self-checking bench for the run-mode clock configuration block: reset values, random
  register writes with readback, clock-tree outputs and the crystal frequency table.
  assumes the block is the only slave on a single-master ahb-lite bus with zero wait states.
*/
`timescale 1ns/1ps
module tb_rmc_clock_config;
  import rmc_pkg::*;
  localparam logic [5:0] MIN_DIV = 6'h04; // divisor floor with the pll, off the default on purpose
  logic hclk, hresetn, hsel, hwrite, hready; // bus control
  logic [31:0] haddr, hwdata; // address and write data
  logic [1:0] htrans; // transfer type
  logic [2:0] hsize; // transfer size
  logic [31:0] hrdata, crystal_hz, got, r, s; // outputs and scratch words
  logic hreadyout, hresp, pll_power_down, sys_clk_from_pll, div_active, auto_gating; // status outputs
  logic main_osc_disable, int_osc_disable; // oscillator disables
  logic [5:0] sys_div_value; // effective divisor
  logic [1:0] oscillator_source_select; // oscillator source
  logic [3:0] crystal_freq_code; // crystal code
  int err_count, check_count; // mismatch and comparison counts
  assign hready = hreadyout; // single slave drives the bus ready
  rmc_clock_config #(.MIN_DIV_LIMIT(MIN_DIV)) rmc_clock_config_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pll_power_down(pll_power_down), .sys_clk_from_pll(sys_clk_from_pll), .div_active(div_active),
    .sys_div_value(sys_div_value), .oscillator_source_select(oscillator_source_select),
    .crystal_freq_code(crystal_freq_code), .crystal_hz(crystal_hz), .auto_gating(auto_gating),
    .main_osc_disable(main_osc_disable), .int_osc_disable(int_osc_disable));
  // free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // compare one value and count it
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // single write: address phase held until ready, then data phase held until ready
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : bus_write
  // single read: data taken at the edge that samples ready in the data phase
  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= 1'b0;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask : bus_read
  // crystal frequency in hertz for each code
  function automatic logic [31:0] crystal_freq_code_hz(input logic [3:0] c);
    case (c)
      4'h0: return 32'd1000000;
      4'h1: return 32'd1843200;
      4'h2: return 32'd2000000;
      4'h3: return 32'd2457600;
      4'h4: return 32'd3579545;
      4'h5: return 32'd3686400;
      4'h6: return 32'd4000000;
      4'h7: return 32'd4096000;
      4'h8: return 32'd4915200;
      4'h9: return 32'd5000000;
      4'ha: return 32'd5120000;
      4'hb: return 32'd6000000;
      4'hc: return 32'd6144000;
      4'hd: return 32'd7372800;
      4'he: return 32'd8000000;
      default: return 32'd8192000;
    endcase
  endfunction : crystal_freq_code_hz
  // effective divisor: override from the second word, floor only while the pll clocks the system
  function automatic logic [5:0] exp_div(input logic [31:0] rv, input logic [31:0] sv);
    logic [5:0] d;
    d = sv[31] ? sv[28:23] : {2'b00, rv[26:23]};
    if (!rv[11] && d < MIN_DIV) d = MIN_DIV;
    return d;
  endfunction : exp_div
  // verdict and end of run
  task automatic final_report;
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    final_report();
  end
  // main sequence
  initial begin
    err_count = 0; check_count = 0; hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = '0;
    void'($urandom(81));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk(pll_power_down, 1);
    chk(sys_clk_from_pll, 0);
    chk(crystal_freq_code, 4'hb);
    chk(crystal_hz, 32'd6000000);
    chk(oscillator_source_select, 2'h1);
    chk(sys_div_value, 6'h0f);
    @(posedge hclk);
    bus_read(RMC_OFS_RUN_CFG, got);
    chk(got, 32'h0780_3ad1);
    for (int i = 0; i < 40; i++) begin
      s = $urandom;
      r = $urandom;
      if (i < 16) r[9:6] = i[3:0];
      if (i == 16) r = 32'hffff_ffff;
      if (i == 17) begin
        r = 32'h0000_0100;
        s = 32'h0;
      end
      // codes meant for oscillator-only use never go out with the pll selected
      if (r[9:6] <= RMC_CRYSTAL_FREQ_CODE_LAST_NO_PLL) r[11] = 1'b1;
      bus_write(RMC_OFS_SECOND_CFG, s);
      bus_write(RMC_OFS_RUN_CFG, r);
      repeat (2) @(posedge hclk);
      #1;
      chk(pll_power_down, r[13]);
      chk(sys_clk_from_pll, !r[11]);
      chk(div_active, r[22] | !r[11]);
      chk(sys_div_value, exp_div(r, s));
      chk(crystal_freq_code, r[9:6]);
      chk(crystal_hz, crystal_freq_code_hz(r[9:6]));
      chk(oscillator_source_select, r[5:4]);
      chk({auto_gating, int_osc_disable, main_osc_disable}, {r[27], r[1], r[0]});
      @(posedge hclk);
      bus_read(RMC_OFS_RUN_CFG, got);
      chk(got, (r & 32'h0fc0_2bf3) | 32'h0000_1000);
      bus_read(RMC_OFS_SECOND_CFG, got);
      chk(got, s & 32'h9f80_0000);
      bus_read(RMC_OFS_STATUS, got);
      chk(got, {18'h0_0000, exp_div(r, s), 5'h00, 1'b0, r[22] | !r[11], !r[11]});
      chk({hreadyout, hresp}, 2'b10);
    end
    bus_write(12'h068, 32'hffff_ffff);
    bus_read(12'h068, got);
    chk(got, 32'h0);
    bus_read(RMC_OFS_RUN_CFG, got);
    chk(got, (r & 32'h0fc0_2bf3) | 32'h0000_1000);
    bus_write(RMC_OFS_STATUS, 32'hffff_ffff);
    bus_read(RMC_OFS_STATUS, got);
    chk(got, {18'h0_0000, exp_div(r, s), 5'h00, 1'b0, r[22] | !r[11], !r[11]});
    final_report();
  end
endmodule : tb_rmc_clock_config
